//--- rtl/fra_file_alu.sv
// file register array, working register and flags for byte file ops
`timescale 1ns/1ps
module fra_file_alu
   import fra_pkg::*;
#(
   parameter int FILE_DEPTH = FRA_FILE_DEPTH
)(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic op_valid_in,
   input wire logic [2:0] op_code_in,
   input wire logic [6:0] file_addr_in,
   input wire logic dest_sel_in,
   input wire logic load_valid_in,
   input wire logic [6:0] load_addr_in,
   input wire logic [7:0] load_data_in,
   input wire logic [6:0] peek_addr_in,
   output logic [7:0] acc_out,
   output logic carry_out,
   output logic zero_out,
   output logic [7:0] result_out,
   output logic dest_out,
   output logic done_out,
   output logic [7:0] peek_data_out
);
   // the array is addressed by a 7-bit file address
   if (FILE_DEPTH < 1 || FILE_DEPTH > FRA_FILE_DEPTH) begin : g_bad_depth
      $error("FILE_DEPTH must lie between 1 and 128");
   end

   logic [7:0] file_q [FILE_DEPTH];
   logic [7:0] file_d [FILE_DEPTH];
   logic [7:0] acc_q, acc_d;
   logic carry_q, carry_d;
   logic zero_q, zero_d;
   logic [7:0] result_q, result_d;
   logic dest_q, dest_d;
   logic done_q, done_d;
   logic [7:0] peek_q, peek_d;
   logic [7:0] src;
   logic [7:0] alu_result;
   logic alu_carry;
   logic alu_carry_upd;
   logic alu_known;
   logic op_go;

   // addresses past the array read as zero
   assign src = (int'(file_addr_in) < FILE_DEPTH) ?
      file_q[file_addr_in] : FRA_ZERO_BYTE;
   assign op_go = op_valid_in && alu_known;

   fra_alu u_alu (
      .op_code_in(op_code_in),
      .src_in(src),
      .acc_in(acc_q),
      .result_out(alu_result),
      .carry_out(alu_carry),
      .carry_upd_out(alu_carry_upd),
      .known_out(alu_known)
   );

   // next state: one op per cycle; a load only when no op is accepted
   always_comb begin
      file_d = file_q;
      acc_d = acc_q;
      carry_d = carry_q;
      zero_d = zero_q;
      result_d = result_q;
      dest_d = dest_q;
      done_d = 1'b0;
      peek_d = (int'(peek_addr_in) < FILE_DEPTH) ?
         file_q[peek_addr_in] : FRA_ZERO_BYTE;
      // an accepted op owns the result, flags and its destination
      if (op_go) begin
         done_d = 1'b1;
         result_d = alu_result;
         dest_d = dest_sel_in;
         zero_d = (alu_result == FRA_ZERO_BYTE);
         // only the shifts move carry; other ops leave it standing
         if (alu_carry_upd) begin
            carry_d = alu_carry;
         end
         if (dest_sel_in == FRA_DEST_ACC) begin
            acc_d = alu_result;
         end else if (int'(file_addr_in) < FILE_DEPTH) begin
            file_d[file_addr_in] = alu_result;
         end
      end else if (load_valid_in && int'(load_addr_in) < FILE_DEPTH) begin
         // loads yield to ops so a write-back is never lost
         file_d[load_addr_in] = load_data_in;
      end
   end

   // registers only
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < FILE_DEPTH; i++) begin
            file_q[i] <= FRA_FILE_RST;
         end
         acc_q <= FRA_ACC_RST;
         carry_q <= FRA_CARRY_RST;
         zero_q <= FRA_ZERO_RST;
         result_q <= FRA_RESULT_RST;
         dest_q <= FRA_DEST_ACC;
         done_q <= 1'b0;
         peek_q <= FRA_ZERO_BYTE;
      end else begin
         file_q <= file_d;
         acc_q <= acc_d;
         carry_q <= carry_d;
         zero_q <= zero_d;
         result_q <= result_d;
         dest_q <= dest_d;
         done_q <= done_d;
         peek_q <= peek_d;
      end
   end

   // outputs straight from flops
   assign acc_out = acc_q;
   assign carry_out = carry_q;
   assign zero_out = zero_q;
   assign result_out = result_q;
   assign dest_out = dest_q;
   assign done_out = done_q;
   assign peek_data_out = peek_q;

   // checks on the datapath, one cycle after issue
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);

   a_inc_sum_out: assert property (
      op_valid_in && op_code_in == FRA_OP_INCREMENT_FILE |=>
      done_out && result_out == 8'($past(src) + FRA_INC_STEP))
      else $error("increment result wrong");
   a_dest_acc_write: assert property (
      op_go && dest_sel_in == FRA_DEST_ACC |=> acc_out == result_out)
      else $error("accumulator not written");
   a_dest_file_write: assert property (
      op_go && dest_sel_in == FRA_DEST_FILE &&
      int'(file_addr_in) < FILE_DEPTH |=>
      file_q[$past(file_addr_in)] == result_out &&
      acc_out == $past(acc_out) && dest_out == FRA_DEST_FILE)
      else $error("file write-back wrong");
   a_or_result_ok: assert property (
      op_valid_in && op_code_in == FRA_OP_OR_ACC_WITH_FILE |=>
      result_out == ($past(acc_q) | $past(src)))
      else $error("or result wrong");
   a_shl_carry_bits: assert property (
      op_valid_in && op_code_in == FRA_OP_SHIFT_LEFT |=>
      result_out == {$past(src[6:0]), 1'b0} && carry_out == $past(src[7]))
      else $error("left shift wrong");
   a_shr_carry_bits: assert property (
      op_valid_in && op_code_in == FRA_OP_SHIFT_RIGHT |=>
      result_out == {1'b0, $past(src[7:1])} && carry_out == $past(src[0]))
      else $error("right shift wrong");
   a_move_keeps_carry: assert property (
      op_valid_in && op_code_in == FRA_OP_MOVE_FILE |=>
      result_out == $past(src) && carry_out == $past(carry_out))
      else $error("move result or carry wrong");
   a_zero_flag_match: assert property (
      done_out |-> zero_out == (result_out == FRA_ZERO_BYTE))
      else $error("zero flag mismatch");
   a_idle_flags_hold: assert property (
      !op_go |=> carry_out == $past(carry_out) &&
      zero_out == $past(zero_out) && !done_out)
      else $error("flags moved without an op");

   // inc and or never touch carry
   a_carry_kept_inc_or: assert property (
      op_go && (op_code_in == FRA_OP_INCREMENT_FILE ||
      op_code_in == FRA_OP_OR_ACC_WITH_FILE) |=>
      carry_out == $past(carry_out))
      else $error("carry moved on a non-shift op");

   // a file-destined move is a pure test: the byte stays as it was
   a_move_test_keeps: assert property (
      op_go && op_code_in == FRA_OP_MOVE_FILE &&
      dest_sel_in == FRA_DEST_FILE && int'(file_addr_in) < FILE_DEPTH |=>
      file_q[$past(file_addr_in)] == $past(src) &&
      zero_out == ($past(src) == FRA_ZERO_BYTE))
      else $error("move test altered the file byte");

   // destination of the last op is reported as issued
   a_dest_latched: assert property (
      op_go |=> dest_out == $past(dest_sel_in))
      else $error("destination not latched");

   // unknown codes: no pulse, no result, no register change
   a_unknown_op_quiet: assert property (
      op_valid_in && !alu_known |=>
      !done_out && result_out == $past(result_out) &&
      acc_out == $past(acc_out))
      else $error("unknown op code had an effect");

   // a load colliding with a write-back must not win
   a_load_yields: assert property (
      op_go && dest_sel_in == FRA_DEST_FILE && load_valid_in &&
      load_addr_in == file_addr_in && int'(file_addr_in) < FILE_DEPTH |=>
      file_q[$past(file_addr_in)] == result_out)
      else $error("load overwrote a write-back");

   c_inc_wraps: cover property (
      op_valid_in && op_code_in == FRA_OP_INCREMENT_FILE &&
      src == 8'hFF ##1 zero_out);
   c_shl_carry_out: cover property (
      op_valid_in && op_code_in == FRA_OP_SHIFT_LEFT && src[7] ##1 carry_out);
   c_move_file_test: cover property (
      op_valid_in && op_code_in == FRA_OP_MOVE_FILE &&
      dest_sel_in == FRA_DEST_FILE ##1 done_out);
   // or written back to the file
   c_or_to_file: cover property (
      op_go && op_code_in == FRA_OP_OR_ACC_WITH_FILE &&
      dest_sel_in == FRA_DEST_FILE ##1 done_out);
   // load and an accepted op (either destination) on one address in one cycle
   c_load_collides: cover property (
      op_go && load_valid_in && load_addr_in == file_addr_in ##1 done_out);
endmodule

//--- rtl/fra_pkg.sv
// constants shared by the file-register byte datapath
package fra_pkg;
   // operand widths and file size
   localparam int FRA_DATA_W = 8;
   localparam int FRA_ADDR_W = 7;
   localparam int FRA_FILE_DEPTH = 128;
   // operation codes on op_code_in
   localparam logic [2:0] FRA_OP_INCREMENT_FILE = 3'h0;
   localparam logic [2:0] FRA_OP_OR_ACC_WITH_FILE = 3'h1;
   localparam logic [2:0] FRA_OP_SHIFT_LEFT = 3'h2;
   localparam logic [2:0] FRA_OP_SHIFT_RIGHT = 3'h3;
   localparam logic [2:0] FRA_OP_MOVE_FILE = 3'h4;
   // destination select encodings
   localparam logic FRA_DEST_ACC = 1'b0;
   localparam logic FRA_DEST_FILE = 1'b1;
   // values after reset and fixed operands
   localparam logic [7:0] FRA_ACC_RST = 8'h00;
   localparam logic [7:0] FRA_FILE_RST = 8'h00;
   localparam logic [7:0] FRA_RESULT_RST = 8'h00;
   localparam logic [7:0] FRA_ZERO_BYTE = 8'h00;
   localparam logic [7:0] FRA_INC_STEP = 8'h01;
   localparam logic FRA_CARRY_RST = 1'b0;
   localparam logic FRA_ZERO_RST = 1'b0;
   // cycles from an accepted op to its result on the ports
   localparam int FRA_RESULT_LATENCY = 1;
endpackage

//--- rtl/fra_alu.sv
// combinational byte unit: result and carry for one operation
`timescale 1ns/1ps
module fra_alu
   import fra_pkg::*;
(
   input wire logic [2:0] op_code_in,
   input wire logic [7:0] src_in,
   input wire logic [7:0] acc_in,
   output logic [7:0] result_out,
   output logic carry_out,
   output logic carry_upd_out,
   output logic known_out
);
   // one mux for all five ops; unknown codes report known_out low
   always_comb begin
      result_out = src_in;
      carry_out = 1'b0;
      carry_upd_out = 1'b0;
      known_out = 1'b1;
      case (op_code_in)
         FRA_OP_INCREMENT_FILE: begin
            result_out = src_in + FRA_INC_STEP;
         end
         FRA_OP_OR_ACC_WITH_FILE: begin
            result_out = acc_in | src_in;
         end
         FRA_OP_SHIFT_LEFT: begin
            result_out = {src_in[6:0], 1'b0};
            carry_out = src_in[7];
            carry_upd_out = 1'b1;
         end
         FRA_OP_SHIFT_RIGHT: begin
            result_out = {1'b0, src_in[7:1]};
            carry_out = src_in[0];
            carry_upd_out = 1'b1;
         end
         FRA_OP_MOVE_FILE: begin
            result_out = src_in;
         end
         default: begin
            known_out = 1'b0;
         end
      endcase
   end
endmodule

//--- testbench/file_register_byte_alu_ops_tb_top.sv
// self-checking bench for the file-register byte datapath
`timescale 1ns/1ps
module file_register_byte_alu_ops_tb_top
   import fra_pkg::*;
;
   logic mclk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic op_valid_in = 1'b0;
   logic [2:0] op_code_in = 3'h0;
   logic [6:0] file_addr_in = 7'h00;
   logic dest_sel_in = 1'b0;
   logic load_valid_in = 1'b0;
   logic [6:0] load_addr_in = 7'h00;
   logic [7:0] load_data_in = 8'h00;
   logic [6:0] peek_addr_in = 7'h00;
   logic [7:0] acc_out, result_out, peek_data_out;
   logic carry_out, zero_out, dest_out, done_out;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;

   fra_file_alu dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
      .op_valid_in(op_valid_in), .op_code_in(op_code_in),
      .file_addr_in(file_addr_in), .dest_sel_in(dest_sel_in),
      .load_valid_in(load_valid_in), .load_addr_in(load_addr_in),
      .load_data_in(load_data_in), .peek_addr_in(peek_addr_in),
      .acc_out(acc_out), .carry_out(carry_out), .zero_out(zero_out),
      .result_out(result_out), .dest_out(dest_out), .done_out(done_out),
      .peek_data_out(peek_data_out));

   // 200 MHz clock
   initial begin
      forever #2.5 mclk_in = ~mclk_in;
   end

   // hang guard, far above the roughly 30 cycles the tests need
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // all drivers start and end on a falling edge
   task automatic load(input logic [6:0] a, input logic [7:0] v);
      load_addr_in = a;
      load_data_in = v;
      load_valid_in = 1'b1;
      @(negedge mclk_in);
      load_valid_in = 1'b0;
   endtask

   // peek answers one edge later, so file changes are already in
   task automatic peek(input logic [6:0] a, input logic [7:0] exp);
      peek_addr_in = a;
      @(negedge mclk_in);
      chk(peek_data_out, exp);
   endtask

   // one op; done stands only in the cycle after it is taken
   task automatic do_op(input logic [2:0] op, input logic [6:0] a,
         input logic d, input logic [7:0] r, input int z, input int c);
      op_code_in = op;
      file_addr_in = a;
      dest_sel_in = d;
      op_valid_in = 1'b1;
      @(negedge mclk_in);
      op_valid_in = 1'b0;
      chk({7'h0, done_out}, 8'h01);
      chk(result_out, r);
      chk({7'h0, zero_out}, 8'(z));
      chk({7'h0, carry_out}, 8'(c));
      chk({7'h0, dest_out}, {7'h0, d});
   endtask

   // wrap to zero in the file, then a plain sum into the accumulator
   task automatic t_inc();
      load(7'h05, 8'hFF);
      do_op(FRA_OP_INCREMENT_FILE, 7'h05, FRA_DEST_FILE, 8'h00, 1, 0);
      peek(7'h05, 8'h00);
      load(7'h06, 8'h7F);
      do_op(FRA_OP_INCREMENT_FILE, 7'h06, FRA_DEST_ACC, 8'h80, 0, 0);
      chk(acc_out, 8'h80);
      peek(7'h06, 8'h7F);
      $display("test inc done");
   endtask

   task automatic t_or();
      load(7'h07, 8'h01);
      do_op(FRA_OP_OR_ACC_WITH_FILE, 7'h07, FRA_DEST_FILE, 8'h81, 0, 0);
      chk(acc_out, 8'h80);
      peek(7'h07, 8'h81);
      $display("test or done");
   endtask

   // edge bits out through carry, zero in at the far end
   task automatic t_shift();
      load(7'h08, 8'h81);
      do_op(FRA_OP_SHIFT_LEFT, 7'h08, FRA_DEST_FILE, 8'h02, 0, 1);
      peek(7'h08, 8'h02);
      do_op(FRA_OP_SHIFT_RIGHT, 7'h08, FRA_DEST_ACC, 8'h01, 0, 0);
      chk(acc_out, 8'h01);
      load(7'h09, 8'h01);
      do_op(FRA_OP_SHIFT_RIGHT, 7'h09, FRA_DEST_FILE, 8'h00, 1, 1);
      load(7'h0A, 8'h80);
      do_op(FRA_OP_SHIFT_LEFT, 7'h0A, FRA_DEST_ACC, 8'h00, 1, 1);
      $display("test shift done");
   endtask

   // move keeps carry; unknown op code leaves everything alone
   task automatic t_move();
      do_op(FRA_OP_MOVE_FILE, 7'h08, FRA_DEST_FILE, 8'h02, 0, 1);
      peek(7'h08, 8'h02);
      do_op(FRA_OP_MOVE_FILE, 7'h07, FRA_DEST_ACC, 8'h81, 0, 1);
      chk(acc_out, 8'h81);
      do_op(FRA_OP_MOVE_FILE, 7'h09, FRA_DEST_ACC, 8'h00, 1, 1);
      chk(acc_out, 8'h00);
      // a move here would give result 81 and clear zero; unknown must not
      op_code_in = 3'h5;
      file_addr_in = 7'h07;
      dest_sel_in = FRA_DEST_ACC;
      op_valid_in = 1'b1;
      @(negedge mclk_in);
      op_valid_in = 1'b0;
      chk({7'h0, done_out}, 8'h00);
      chk({7'h0, zero_out}, 8'h01);
      chk({7'h0, carry_out}, 8'h01);
      chk(result_out, 8'h00);
      chk(acc_out, 8'h00);
      $display("test move done");
   endtask

   // a load in the cycle of an op yields; inc leaves carry alone
   task automatic t_race();
      load_addr_in = 7'h07;
      load_data_in = 8'h55;
      load_valid_in = 1'b1;
      do_op(FRA_OP_INCREMENT_FILE, 7'h07, FRA_DEST_FILE, 8'h82, 0, 1);
      load_valid_in = 1'b0;
      peek(7'h07, 8'h82);
      $display("test race done");
   endtask

   // reset for 5 cycles, then the scenarios
   initial begin
      repeat (5) @(negedge mclk_in);
      rst_b_in = 1'b1;
      chk(acc_out, FRA_ACC_RST);
      chk({7'h0, zero_out}, 8'h00);
      chk({7'h0, done_out}, 8'h00);
      t_inc();
      t_or();
      t_shift();
      t_move();
      t_race();
      close_out();
   end
endmodule
